// ==== src/exc_ctrl_defs.svh ====
`ifndef EXC_CTRL_DEFS_SVH
`define EXC_CTRL_DEFS_SVH

`define REG_FIELD_LO      16'hff80
`define OFFCHIP_LO        16'h8000
`define OFFCHIP_HI        16'hfb7f
`define RAM_LO            16'hfb80
`define RAM_HI            16'hff7f

`define NMI_LEVEL         4'h8
`define MASK_RESET        3'h7
`define NUM_SRC           8

`define ADR_CTRL          32'h0000_0000
`define ADR_STATUS        32'h0000_0004
`define ADR_PRIO          32'h0000_0008
`define ADR_DTE           32'h0000_000c
`define ADR_CAUSE         32'h0000_0010

`define CTRL_RAM_EN_BIT   0
`define CTRL_RESET        32'h0000_0001

`endif

// ==== src/exc_ctrl_pkg.sv ====
package exc_ctrl_pkg;

   typedef enum logic [3:0] {
      EXC_NONE    = 4'h0,
      EXC_ADDR    = 4'h1,
      EXC_TRACE   = 4'h2,
      EXC_IRQ     = 4'h3,
      EXC_INVALID = 4'h4,
      EXC_UNCONDITIONAL_TRAP_INSTR   = 4'h5,
      EXC_TRAPVS  = 4'h6,
      EXC_ZDIV    = 4'h7,
      EXC_NMI     = 4'h8
   } exc_cause_t;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_XFER = 2'b01
   } exc_state_t;

endpackage

// ==== src/cpu_exception_control.sv ====
`include "exc_ctrl_defs.svh"

// Functional notes
// - Prefetch in register field raises address error
// - Address error clears trace, keeps mask
// - Prefetch error handled after instruction completes
// - Odd word access raises address error
// - Single-chip: unmapped region access errors
// - Single-chip: disabled RAM access errors
// - Trace flag set: trace each instruction
// - Trace clears flag, keeps mask
// - Stacked status has trace flag set
// - Address error beats coinciding trace
// - Priorities 0 to 7, NMI level 8
// - Accept above mask, arbitrate, keep pending
// - Transfer enable starts engine, else interrupt
// - CPU halted during engine transfer
// - Interrupt clears trace, loads mask level
// - Invalid instruction: clear trace, keep mask
// - Trap, divide clear trace; interrupt follows
// - Unconditional trap selects one of sixteen
// - Overflow trap conditional; zero divide raises
// - Defer address error, trace, interrupts after control instructions
// - Block all interrupts after reset
// - One instruction after transfer before interrupts
module cpu_exception_control
   import exc_ctrl_pkg::*;
#(
   parameter int NSRC = `NUM_SRC
)
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              single_chip_mode_i,
   input  wire logic              bus_valid_i,
   input  wire logic              bus_prefetch_i,
   input  wire logic              bus_word_i,
   input  wire logic [15:0]       bus_addr_i,
   input  wire logic              instr_done_i,
   input  wire logic              instr_ctrl_group_i,
   input  wire logic              instr_invalid_i,
   input  wire logic              instr_unconditional_trap_instr_i,
   input  wire logic [3:0]        unconditional_trap_instr_vector_i,
   input  wire logic              instr_trapvs_i,
   input  wire logic              overflow_flag_i,
   input  wire logic              instr_unsigned_divide_instr_i,
   input  wire logic              divisor_zero_i,
   input  wire logic              instr_rte_i,
   input  wire logic              rte_trace_flag_i,
   input  wire logic [2:0]        rte_mask_level_i,
   input  wire logic              nmi_i,
   input  wire logic [NSRC-1:0]   irq_i,
   input  wire logic              xfer_done_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [4:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   output logic                   wb_err_o,
   output logic                   exc_start_o,
   output logic [3:0]             exc_cause_o,
   output logic [7:0]             exc_vector_o,
   output logic                   stacked_trace_o,
   output logic                   trace_flag_o,
   output logic [2:0]             interrupt_mask_level_o,
   output logic                   xfer_start_o,
   output logic [2:0]             xfer_source_o,
   output logic                   cpu_halt_o
);

   typedef struct packed {
      logic                  mode_sync1;
      logic                  mode_sync2;
      logic                  mode_latched;
      logic                  mode_taken;
      logic [1:0]            mode_cnt;
      logic                  nmi_sync1;
      logic                  nmi_sync2;
      logic                  nmi_prev;
      logic                  nmi_pend;
      logic [NSRC-1:0]       irq_sync1;
      logic [NSRC-1:0]       irq_sync2;
      logic                  pf_err;
      logic                  data_err;
      logic                  halt;
      logic                  block;
      exc_state_t            state;
      logic                  trace;
      logic [2:0]            mask;
      logic                  onchip_ram_enable;
      logic [31:0]           priority_setting_regs;
      logic [NSRC-1:0]       transfer_enable_bits;
      logic [3:0]            last_cause;
      logic                  exc_start;
      logic [3:0]            cause;
      logic [7:0]            vector;
      logic                  stacked_trace;
      logic                  xfer_start;
      logic [2:0]            xfer_src;
      logic [31:0]           dat;
      logic                  ack;
      logic                  err;
   } state_t;

   state_t q;
   state_t d;

   function automatic logic [2:0] src_prio(input logic [31:0] regs,
                                           input int          idx);
      src_prio = regs[idx*4 +: 3];
   endfunction

   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic        ram_off;
   logic        addr_err_now;
   logic        pf_err_now;
   logic        best_hit;
   logic [2:0]  best_idx;
   logic [2:0]  best_lvl;
   logic        accept_ok;
   logic        wb_hit;
   logic        wb_known;

   always_comb
   begin
      d = q;
      d.exc_start  = 1'b0;
      d.xfer_start = 1'b0;
      d.ack        = 1'b0;
      d.err        = 1'b0;
      d.mode_sync1 = single_chip_mode_i;
      d.mode_sync2 = q.mode_sync1;
      // The strap is taken once the synchroniser holds a sample from after
      // reset; its flops are cleared by reset and would read as expanded.
      if (!q.mode_taken)
      begin
         if (q.mode_cnt == 2'h2)
         begin
            d.mode_latched = q.mode_sync2;
            d.mode_taken   = 1'b1;
         end
         else
            d.mode_cnt = q.mode_cnt + 2'h1;
      end
      d.nmi_sync1 = nmi_i;
      d.nmi_sync2 = q.nmi_sync1;
      d.nmi_prev  = q.nmi_sync2;
      d.irq_sync1 = irq_i;
      d.irq_sync2 = q.irq_sync1;
      if (q.nmi_sync2 && !q.nmi_prev)
         d.nmi_pend = 1'b1;

      // Bus cycle checks.
      ram_off = q.mode_latched && !q.onchip_ram_enable;
      pf_err_now = bus_valid_i && bus_prefetch_i
                   && (bus_addr_i >= `REG_FIELD_LO);
      addr_err_now = pf_err_now
         || (bus_valid_i && bus_word_i && bus_addr_i[0])
         || (bus_valid_i && q.mode_latched
             && in_range(bus_addr_i, `OFFCHIP_LO, `OFFCHIP_HI))
         || (bus_valid_i && ram_off
             && in_range(bus_addr_i, `RAM_LO, `RAM_HI));
      if (pf_err_now)
         d.pf_err = 1'b1;
      else if (addr_err_now)
         d.data_err = 1'b1;

      // Interrupt arbitration: highest level wins, lower index on ties.
      best_hit = 1'b0;
      best_idx = 3'h0;
      best_lvl = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--)
      begin
         if (q.irq_sync2[i] && src_prio(q.priority_setting_regs, i) != 3'h0
             && src_prio(q.priority_setting_regs, i) > q.mask
             && (!best_hit
                 || src_prio(q.priority_setting_regs, i) >= best_lvl))
         begin
            best_hit = 1'b1;
            best_idx = 3'(i);
            best_lvl = src_prio(q.priority_setting_regs, i);
         end
      end
      accept_ok = !q.block;

      unique case (q.state)
         ST_RUN:
         begin
            if (instr_done_i)
            begin
               d.block = 1'b0;
               // An error seen during a control instruction waits for the
               // next instruction outside that group.
               if (!instr_ctrl_group_i)
               begin
                  d.pf_err   = 1'b0;
                  d.data_err = 1'b0;
               end
               if (instr_rte_i)
               begin
                  d.trace = rte_trace_flag_i;
                  d.mask  = rte_mask_level_i;
               end
               if ((q.pf_err || pf_err_now || q.data_err || addr_err_now)
                   && !instr_ctrl_group_i)
               begin
                  d.exc_start = 1'b1;
                  d.cause  = EXC_ADDR;
                  d.vector = 8'h08;
                  d.trace  = 1'b0;
                  d.stacked_trace = q.trace;
               end
               else if (instr_invalid_i)
               begin
                  d.exc_start = 1'b1;
                  d.cause  = EXC_INVALID;
                  d.vector = 8'h02;
                  d.trace  = 1'b0;
                  d.stacked_trace = q.trace;
               end
               else if (instr_unconditional_trap_instr_i
                        || (instr_trapvs_i && overflow_flag_i))
               begin
                  d.exc_start = 1'b1;
                  d.cause  = instr_unconditional_trap_instr_i ? EXC_UNCONDITIONAL_TRAP_INSTR : EXC_TRAPVS;
                  d.vector = instr_unconditional_trap_instr_i ? {4'h1, unconditional_trap_instr_vector_i}
                                           : 8'h04;
                  d.trace  = 1'b0;
                  d.stacked_trace = q.trace;
               end
               else if (instr_unsigned_divide_instr_i && divisor_zero_i)
               begin
                  d.exc_start = 1'b1;
                  d.cause  = EXC_ZDIV;
                  d.vector = 8'h03;
                  d.trace  = 1'b0;
                  d.stacked_trace = q.trace;
               end
               else if (q.trace && !instr_ctrl_group_i)
               begin
                  d.exc_start = 1'b1;
                  d.cause  = EXC_TRACE;
                  d.vector = 8'h09;
                  d.trace  = 1'b0;
                  d.stacked_trace = 1'b1;
               end
               else if (accept_ok && !instr_ctrl_group_i && q.nmi_pend)
               begin
                  d.exc_start = 1'b1;
                  d.cause  = EXC_NMI;
                  d.vector = 8'h0b;
                  d.trace  = 1'b0;
                  d.mask   = `MASK_RESET;
                  // An edge arriving in this very cycle stays pending.
                  d.nmi_pend = q.nmi_sync2 && !q.nmi_prev;
                  d.stacked_trace = q.trace;
               end
               else if (accept_ok && !instr_ctrl_group_i && best_hit)
               begin
                  if (q.transfer_enable_bits[best_idx])
                  begin
                     d.xfer_start = 1'b1;
                     d.xfer_src   = best_idx;
                     d.state      = ST_XFER;
                  end
                  else
                  begin
                     d.exc_start = 1'b1;
                     d.cause  = EXC_IRQ;
                     d.vector = 8'h20 + {5'h0, best_idx};
                     d.trace  = 1'b0;
                     d.mask   = best_lvl;
                     d.stacked_trace = q.trace;
                  end
               end
               if (d.exc_start)
                  d.last_cause = d.cause;
            end
         end
         ST_XFER:
         begin
            if (xfer_done_i)
            begin
               d.state = ST_RUN;
               d.block = 1'b1;
            end
         end
         default:
            d.state = ST_RUN;
      endcase

      d.halt = (d.state == ST_XFER);

      // Wishbone slave, one wait state, ack held one cycle.
      wb_hit = wb_cyc_i && wb_stb_i && !q.ack && !q.err;
      wb_known = (wb_adr_i[4:2] <= 3'h4) && (wb_adr_i[1:0] == 2'b00);
      if (wb_hit)
      begin
         d.ack = wb_known;
         d.err = !wb_known;
         d.dat = 32'h0;
         if (wb_known)
         begin
            unique case ({27'h0, wb_adr_i})
               `ADR_CTRL:
               begin
                  d.dat = {31'h0, q.onchip_ram_enable};
                  if (wb_we_i && wb_sel_i[0])
                     d.onchip_ram_enable = wb_dat_i[`CTRL_RAM_EN_BIT];
               end
               `ADR_STATUS:
                  d.dat = {20'h0, q.last_cause, 1'b0, q.state == ST_XFER,
                           q.nmi_pend, q.trace, 1'b0, q.mask};
               `ADR_PRIO:
               begin
                  d.dat = q.priority_setting_regs;
                  if (wb_we_i)
                     for (int b = 0; b < 4; b++)
                        if (wb_sel_i[b])
                           d.priority_setting_regs[b*8 +: 8] =
                              wb_dat_i[b*8 +: 8];
               end
               `ADR_DTE:
               begin
                  d.dat = 32'(q.transfer_enable_bits);
                  if (wb_we_i && wb_sel_i[0])
                     d.transfer_enable_bits = wb_dat_i[NSRC-1:0];
               end
               default:
                  d.dat = {28'h0, q.cause};
            endcase
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.block <= 1'b1;
         q.trace <= 1'b0;
         q.mask  <= `MASK_RESET;
         q.onchip_ram_enable <= 1'(`CTRL_RESET);
         q.state <= ST_RUN;
      end
      else
         q <= d;
   end

   assign wb_dat_o               = q.dat;
   assign wb_ack_o               = q.ack;
   assign wb_err_o               = q.err;
   assign exc_start_o            = q.exc_start;
   assign exc_cause_o            = q.cause;
   assign exc_vector_o           = q.vector;
   assign stacked_trace_o        = q.stacked_trace;
   assign trace_flag_o           = q.trace;
   assign interrupt_mask_level_o = q.mask;
   assign xfer_start_o           = q.xfer_start;
   assign xfer_source_o          = q.xfer_src;
   assign cpu_halt_o             = q.halt;

endmodule

// ==== test/xfer_engine_model.sv ====
module xfer_engine_model
(
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic [4:0] dly_i,
   output logic            done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt_q = 5'h00;

   // Ends each transfer with a one-cycle pulse, dly_i+1 cycles after start; a dly_i of zero gives no pulse.
   initial done_o = 1'b0;
   always @(posedge clk_i)
   begin
      done_o <= cnt_q == 5'h01;
      if (start_i)
         cnt_q <= dly_i;
      else if (cnt_q != 5'h00)
         cnt_q <= cnt_q - 5'h01;
   end
endmodule

// ==== test/cpu_exception_control_properties.sv ====
module exc_checker
   import exc_ctrl_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        bus_valid_i,
   input wire logic        bus_prefetch_i,
   input wire logic        bus_word_i,
   input wire logic [15:0] bus_addr_i,
   input wire logic        instr_done_i,
   input wire logic        instr_ctrl_group_i,
   input wire logic        xfer_done_i,
   input wire logic        exc_start_o,
   input wire logic [3:0]  exc_cause_o,
   input wire logic        stacked_trace_o,
   input wire logic        trace_flag_o,
   input wire logic [2:0]  interrupt_mask_level_o,
   input wire logic        xfer_start_o,
   input wire logic        cpu_halt_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic seen_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Set once an instruction has finished since reset.
   always_ff @(posedge clk_i)
      if (rst_i)
         seen_q <= 1'b0;
      else if (instr_done_i)
         seen_q <= 1'b1;

   sequence s_bad;
      bus_valid_i && (bus_word_i && bus_addr_i[0]
         || bus_prefetch_i && bus_addr_i >= 16'hff80);
   endsequence
   sequence s_plain;
      instr_done_i && !instr_ctrl_group_i;
   endsequence

   property p_bad;
      s_bad ##1 s_plain |=> exc_start_o && exc_cause_o == EXC_ADDR;
   endproperty
   a_bad: assert property (p_bad)
      else $error("bad access not faulted");
   property p_after;
      exc_start_o |-> $past(instr_done_i);
   endproperty
   a_after: assert property (p_after)
      else $error("exception started mid instruction");
   property p_tclr;
      exc_start_o |-> ##[0:1] !trace_flag_o;
   endproperty
   a_tclr: assert property (p_tclr)
      else $error("trace flag kept on exception");
   property p_keep;
      exc_start_o && !(exc_cause_o inside {EXC_IRQ, EXC_NMI})
         |-> $stable(interrupt_mask_level_o);
   endproperty
   a_keep: assert property (p_keep)
      else $error("mask level changed");
   property p_raise;
      exc_start_o && exc_cause_o == EXC_IRQ
         |-> interrupt_mask_level_o > $past(interrupt_mask_level_o);
   endproperty
   a_raise: assert property (p_raise)
      else $error("interrupt did not raise mask");
   property p_img;
      exc_start_o && exc_cause_o == EXC_TRACE |-> stacked_trace_o;
   endproperty
   a_img: assert property (p_img)
      else $error("stacked trace bit clear");
   property p_defer;
      instr_done_i && instr_ctrl_group_i |=> !exc_start_o && !xfer_start_o;
   endproperty
   a_defer: assert property (p_defer)
      else $error("exception after control instruction");
   property p_first;
      instr_done_i && !seen_q |=> !xfer_start_o
         && !(exc_start_o && exc_cause_o inside {EXC_IRQ, EXC_NMI});
   endproperty
   a_first: assert property (p_first)
      else $error("interrupt before first instruction");
   property p_halt;
      cpu_halt_o && !xfer_done_i |=> cpu_halt_o && !exc_start_o;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt dropped during transfer");
endmodule

bind cpu_exception_control exc_checker chk_u (.*);

// ==== test/cpu_exception_control_tb.sv ====
module cpu_exception_control_tb
   import exc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0, rst_i = 1'b1, single_chip_mode_i = 1'b1;
   logic        bus_valid_i = 1'b0, bus_prefetch_i = 1'b0, bus_word_i = 1'b0;
   logic        instr_done_i = 1'b0, nmi_i = 1'b0, rte_trace_flag_i = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, er;
   logic [15:0] bus_addr_i = 16'h0000;
   logic [7:0]  fl = 8'h00, irq_i = 8'h00, exc_vector_o;
   logic [2:0]  rte_mask_level_i = 3'h0, interrupt_mask_level_o, xfer_source_o;
   logic [3:0]  unconditional_trap_instr_vector_i = 4'h0, wb_sel_i = 4'h0, exc_cause_o;
   logic [4:0]  wb_adr_i = 5'h00, dly = 5'h01, exq[$];
   logic [31:0] wb_dat_i = 32'h0, lf = 32'h00017bf0, rd, wb_dat_o;
   logic        instr_rte_i, instr_ctrl_group_i, instr_invalid_i, instr_unconditional_trap_instr_i;
   logic        instr_trapvs_i, overflow_flag_i, instr_unsigned_divide_instr_i, divisor_zero_i;
   logic        xfer_done_i, wb_ack_o, wb_err_o, exc_start_o, stacked_trace_o;
   logic        trace_flag_o, xfer_start_o, cpu_halt_o;
   logic [18:0] tab[8];
   int          n_mismatch = 0, num_checks = 0, n;

   assign {instr_rte_i, instr_ctrl_group_i, instr_invalid_i, instr_unconditional_trap_instr_i,
      instr_trapvs_i, overflow_flag_i, instr_unsigned_divide_instr_i, divisor_zero_i} = fl;
   cpu_exception_control dut_u (.*);
   xfer_engine_model eng_u (.clk_i(clk_i), .start_i(xfer_start_o),
      .dly_i(dly), .done_o(xfer_done_i));

   initial forever #10 clk_i = ~clk_i;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Completes one instruction; e is the event expected from it, 0 for none.
   task automatic ins(input logic [7:0] f, input logic [4:0] e);
      fl <= f;
      instr_done_i <= 1'b1;
      if (e != 5'h00)
         exq.push_back(e);
      @(posedge clk_i);
      fl <= 8'h00;
      instr_done_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic acc(input logic p, w, input logic [15:0] a, input logic x);
      bus_valid_i <= 1'b1;
      bus_prefetch_i <= p;
      bus_word_i <= w;
      bus_addr_i <= a;
      @(posedge clk_i);
      bus_valid_i <= 1'b0;
      ins(8'h00, x ? 5'(EXC_ADDR) : 5'h00);
   endtask
   task automatic ret_sr(input logic t, input logic [2:0] m);
      rte_trace_flag_i <= t;
      rte_mask_level_i <= m;
      ins(8'hc0, 5'h00);
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int c = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do
         @(posedge clk_i);
      while (!(wb_ack_o | wb_err_o) && c++ < 20);
      if (!(wb_ack_o | wb_err_o))
         n_mismatch++;
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   always @(posedge clk_i)
      if (!rst_i && (exc_start_o | xfer_start_o) === 1'b1)
         check(xfer_start_o ? {2'b10, xfer_source_o} : {1'b0, exc_cause_o},
            exq.size() > 0 ? exq.pop_front() : 5'h00);

   initial
   begin
      repeat (5000) @(posedge clk_i);
      n_mismatch++;
      print_verdict();
   end

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(interrupt_mask_level_o, 3'h7);
      wb(1'b0, 5'h04, 32'h0);
      check(rd[4:0], 5'h07);
      wb(1'b0, 5'h00, 32'h0);
      check(rd[0], 1'b1);
      wb(1'b0, 5'h14, 32'h0);
      check(er, 1'b1);
      nmi_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      ins(8'h00, 5'h00);
      ins(8'h00, 5'(EXC_NMI));
      nmi_i <= 1'b0;
      $display("test reset done");
      ret_sr(1'b0, 3'h0);
      lf = lfsr(lf);
      tab = '{{3'b101, 16'hff80}, {3'b101, 16'hffff}, {3'b011, lf[15:1], 1'b1},
         {3'b010, 1'b0, lf[14:1], 1'b0}, {3'b001, 16'h8000},
         {3'b101, 16'hfb7f}, {3'b000, 16'h7fff}, {3'b010, 16'hfb80}};
      foreach (tab[i])
         acc(tab[i][18], tab[i][17], tab[i][15:0], tab[i][16]);
      wb(1'b1, 5'h00, 32'h0);
      acc(1'b0, 1'b0, 16'hfb80, 1'b1);
      acc(1'b1, 1'b0, 16'hff7f, 1'b1);
      wb(1'b1, 5'h00, 32'h1);
      $display("test address done");
      unconditional_trap_instr_vector_i <= lf[19:16];
      ins(8'h20, 5'(EXC_INVALID));
      ins(8'h10, 5'(EXC_UNCONDITIONAL_TRAP_INSTR));
      check(exc_vector_o, {4'h1, lf[19:16]});
      ins(8'h0c, 5'(EXC_TRAPVS));
      ins(8'h08, 5'h00);
      ins(8'h03, 5'(EXC_ZDIV));
      ins(8'h02, 5'h00);
      check(interrupt_mask_level_o, 3'h0);
      $display("test traps done");
      ret_sr(1'b1, 3'h0);
      ins(8'h40, 5'h00);
      ins(8'h00, 5'(EXC_TRACE));
      check(trace_flag_o, 1'b0);
      check(stacked_trace_o, 1'b1);
      ret_sr(1'b1, 3'h0);
      acc(1'b0, 1'b1, 16'h0101, 1'b1);
      ins(8'h00, 5'h00);
      $display("test trace done");
      wb(1'b1, 5'h08, 32'h53);
      wb(1'b1, 5'h0c, 32'h0);
      ret_sr(1'b0, 3'h4);
      irq_i <= 8'h01;
      repeat (4) @(posedge clk_i);
      ins(8'h00, 5'h00);
      irq_i <= 8'h03;
      repeat (4) @(posedge clk_i);
      ins(8'h00, 5'(EXC_IRQ));
      irq_i <= 8'h01;
      check(interrupt_mask_level_o, 3'h5);
      ret_sr(1'b0, 3'h2);
      ins(8'h00, 5'(EXC_IRQ));
      irq_i <= 8'h00;
      check(interrupt_mask_level_o, 3'h3);
      $display("test interrupt done");
      wb(1'b1, 5'h0c, 32'h1);
      ret_sr(1'b0, 3'h0);
      for (int k = 0; k < 2; k++)
      begin
         lf = lfsr(lf);
         dly <= k ? {1'b1, lf[3:0]} : 5'h01;
         irq_i <= 8'h01;
         repeat (4) @(posedge clk_i);
         ins(8'h00, 5'h10);
         irq_i <= 8'h00;
         nmi_i <= k[0];
         n = 0;
         while (cpu_halt_o !== 1'b0 && n++ < 40)
            @(posedge clk_i);
         check(cpu_halt_o, 1'b0);
         ins(8'h00, 5'h00);
         if (k == 1)
            ins(8'h00, 5'(EXC_NMI));
         nmi_i <= 1'b0;
      end
      $display("test transfer done");
      rst_i <= 1'b1;
      single_chip_mode_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      check(interrupt_mask_level_o, 3'h7);
      acc(1'b0, 1'b1, 16'h8000, 1'b0);
      acc(1'b1, 1'b0, 16'hfb00, 1'b0);
      acc(1'b0, 1'b1, 16'h9001, 1'b1);
      check(exq.size(), 32'h0);
      $display("test expanded done");
      print_verdict();
   end
endmodule
